// ===== include/nic_defs.svh
// Notes on behaviour
// - four priority registers reset to FFh, RW; register four bits 7:4 read-only ones
// - each slot except reset and trap owns a two-bit field coded like current priority
// - pair codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3 masked
// - writing pattern 10 into a field is ignored; that field keeps its old value
// - reset, trap and top-level entry set both current priority bits
// - top-level field is readable and writable but never used by arbitration
// - field x belongs to slot x; slot 0 highest vector pair, slot 13 lowest
// - priority change during service re-enters x only if pending and now higher
// - enable, wait, halt instructions load 10; disable and trap load 11
// - masked jump when current bits are 11, unmasked jump otherwise
// - halt, pop, enable, disable, wait change priority until next return or such instruction
// - reset FFFEh, trap FFFCh, slot 0 FFFAh, each slot two bytes lower
// - fixed order slot 0 highest to 13 lowest; slots 6 and 7 unused
// - listed sources wake from halt; time base wakes only active-halt
// - serial port slot never wakes halt; its receive pin group does instead
// - four independent external groups with four selectable sensitivities
// - sensitivity codes: 00 fall and low, 01 rise, 10 fall, 11 both
// - sensitivity changes only while current priority is level 3
// - a differing sensitivity write clears that group's pending request
// - maskable request served only when enabled and above current level, else pending
// - highest software level wins, ties to lowest slot; entry loads winner field
//
// constants shared by the controller and the external sense block
// assumes a single 100 MHz core clock domain
`ifndef NIC_DEFS_SVH
`define NIC_DEFS_SVH
`define ADDR_ISP0      8'h25
`define ADDR_SENS      8'h29
`define NUM_ISP        4
`define ISP_RESET      8'hFF
`define ISP3_RO_MASK   8'hF0
`define SENS_RESET     8'h00
`define PRIO_L0        2'h2
`define PRIO_L1        2'h1
`define PRIO_L2        2'h0
`define PRIO_L3        2'h3
`define LVL_TOP        3'h4
`define SENS_FALL_LOW  2'h0
`define SENS_RISE      2'h1
`define SENS_FALL      2'h2
`define PIN_IDLE       4'hF
`define NUM_SLOTS      14
`define NUM_GROUPS     4
`define SLOT_TLI       4'h0
`define SLOT_EXT_LO    4'h2
`define SLOT_EXT_HI    4'h5
`define SLOT_USED_MASK 14'h3F3F
`define WAKE_HALT      14'h213D
`define WAKE_AHALT     14'h213F
`define AVD_MASK       14'h0008
`define VEC_RESET      16'hFFFE
`define VEC_TRAP       16'hFFFC
`define VEC_SLOT0      16'hFFFA
`define CC_HI_BIT      5
`define CC_LO_BIT      3
`endif

// ===== include/nic_pkg.sv
// types for the nested interrupt controller
// assumes nic_defs.svh is on the include path
package nic_pkg;
`include "nic_defs.svh"

  typedef logic [1:0] prio_t;

  // controller state, registered as one word
  typedef struct packed {
    logic [3:0][7:0] isp;
    logic [7:0]      sens;
    prio_t           cur;
    logic [7:0]      rdata;
    logic            valid;
    logic [3:0]      slot;
    logic [15:0]     vaddr;
    logic            wake_h;
    logic            wake_ah;
    logic            jump_if_masked_instr;
    logic            jump_if_unmasked_instr;
  } ctrl_state_t;

  // external group sense state
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [3:0] latch;
    logic [3:0] pend;
  } sense_state_t;
endpackage

// ===== src/ext_group_sense.sv
// external interrupt group sensitivity and pending latch
// assumes pins are asynchronous; clears come from core-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "nic_defs.svh"
module ext_group_sense
  import nic_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // pins and controls
  input  wire logic [3:0] i_pin,
  input  wire logic [7:0] i_sens,
  input  wire logic [3:0] i_clr,
  input  wire logic [3:0] i_ack,
  // pending requests
  output logic      [3:0] o_pend
);

  sense_state_t q;
  sense_state_t d;
  logic [3:0]   ev;
  logic [3:0]   low_lvl;

  // per group event decode from the synchronised pin
  for (genvar g = 0; g < `NUM_GROUPS; g++)
  begin : g_grp
    logic [1:0] mode;
    logic       rise;
    logic       fall;
    assign mode       = i_sens[2*g +: 2];
    assign rise       = q.sync2[g] & ~q.prev[g];
    assign fall       = ~q.sync2[g] & q.prev[g];
    assign ev[g]      = (mode == `SENS_RISE) ? rise :
                        ((mode == `SENS_FALL) || (mode == `SENS_FALL_LOW)) ? fall :
                        (rise | fall);
    assign low_lvl[g] = (mode == `SENS_FALL_LOW) & ~q.sync2[g];
  end

  // next state; a new edge wins over a clear in the same cycle
  always_comb
  begin
    d       = q;
    d.sync1 = i_pin;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.latch = (q.latch & ~i_clr & ~i_ack) | ev;
    d.pend  = d.latch | low_lvl;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q       <= '0;
      q.sync1 <= `PIN_IDLE;                                            // no false edge after reset
      q.sync2 <= `PIN_IDLE;
      q.prev  <= `PIN_IDLE;
    end
    else
      q <= d;
  end

  assign o_pend = q.pend;

endmodule
`default_nettype wire

// ===== src/nested_priority_interrupt_ctrl.sv
// nested priority interrupt controller: priority registers, arbiter,
// vector mapping, halt wake-up and current priority tracking
// assumes requests come already enabled from same-clock peripherals
// and that the core samples the winner at instruction boundaries
`timescale 1ns/1ps
`default_nettype none
`include "nic_defs.svh"
module nested_priority_interrupt_ctrl
  import nic_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // interrupt sources
  input  wire logic [13:0] i_irq_req,
  input  wire logic [3:0]  i_ext_pin,
  // core instruction events
  input  wire logic        i_op_rim,
  input  wire logic        i_op_sim,
  input  wire logic        i_op_halt,
  input  wire logic        i_op_wfi,
  input  wire logic        i_op_trap,
  input  wire logic        i_op_interrupt_return_instr,
  input  wire logic        i_op_pop_condition_instr,
  input  wire logic [7:0]  i_pop_condition_instr_data,
  input  wire logic        i_int_ack,
  // power mode status from the core
  input  wire logic        i_in_halt,
  input  wire logic        i_in_active_halt,
  // results to the core
  output logic      [1:0]  o_cur_prio,
  output logic             o_irq_valid,
  output logic      [3:0]  o_vector_slot,
  output logic      [15:0] o_vector_addr,
  output logic             o_wake_halt,
  output logic             o_wake_active_halt,
  output logic             o_jrm_taken,
  output logic             o_jump_if_unmasked_instr_taken
);

  // ***************************************************************
  // declarations
  // ***************************************************************

  ctrl_state_t q;
  ctrl_state_t d;

  logic [3:0]  ext_pend;
  logic [3:0]  ext_clr;
  logic [3:0]  ext_ack;
  logic [13:0] ext_vec;
  logic [13:0] req_all;
  logic [13:0] wake_src;
  logic [13:0] req_eff;
  logic [13:0] elig;
  logic [13:0] used_slots;
  logic [13:0] halt_wake;
  logic [2:0]  score [`NUM_SLOTS];
  logic [2:0]  cur_lvl;
  logic [2:0]  best_lvl;
  logic [3:0]  best_slot;
  logic        acked;

  // level of a priority pair, larger is more urgent
  function automatic logic [2:0] lvl(input prio_t p);
    case (p)
      `PRIO_L0: lvl = 3'h0;
      `PRIO_L1: lvl = 3'h1;
      `PRIO_L2: lvl = 3'h2;
      default:  lvl = 3'h3;
    endcase
  endfunction

  // ***************************************************************
  // external groups
  // ***************************************************************

  ext_group_sense u_sense (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_ext_pin),
    .i_sens    (q.sens),
    .i_clr     (ext_clr),
    .i_ack     (ext_ack),
    .o_pend    (ext_pend)
  );

  // groups feed slots 2 to 5, ored with shared sources
  assign ext_vec = {8'h00, ext_pend, 2'h0};
  assign req_all = i_irq_req | ext_vec;

  // avd shares slot 3 but cannot wake; the serial port slot is masked
  // and only its receive pin, routed to a group, wakes the part
  assign wake_src = (i_irq_req & ~`AVD_MASK) | ext_vec;

  // slot masks as vectors so they can be indexed per slot
  assign used_slots = `SLOT_USED_MASK;
  assign halt_wake  = `WAKE_HALT;

  // leaving halt, only wake-capable sources may be served first
  always_comb
  begin
    if (i_in_halt)
      req_eff = wake_src & `WAKE_HALT;
    else if (i_in_active_halt)
      req_eff = wake_src & `WAKE_AHALT;
    else
      req_eff = req_all;
  end

  // ***************************************************************
  // arbitration
  // ***************************************************************

  assign cur_lvl = lvl(q.cur);

  // per slot score; the top-level field is ignored and scores above all
  for (genvar g = 0; g < `NUM_SLOTS; g++)
  begin : g_slot
    prio_t fld;
    assign fld      = q.isp[g / 4][(g % 4) * 2 +: 2];
    assign score[g] = (g == 0) ? `LVL_TOP : lvl(fld);
    assign elig[g]  = req_eff[g] && used_slots[g] && (score[g] > cur_lvl);
  end

  // walk from highest slot downward so equal levels go to the lower slot
  always_comb
  begin
    best_lvl  = 3'h0;
    best_slot = `SLOT_TLI;
    for (int s = `NUM_SLOTS - 1; s >= 0; s--)
    begin
      if (elig[s] && (score[s] >= best_lvl))
      begin
        best_lvl  = score[s];
        best_slot = 4'(s);
      end
    end
  end

  // entry is acknowledged against the winner the core sampled
  assign acked = i_int_ack & q.valid;

  // edge latches of a served group clear on entry
  always_comb
  begin
    ext_ack = 4'h0;
    if (acked && (q.slot >= `SLOT_EXT_LO) && (q.slot <= `SLOT_EXT_HI))
      ext_ack[2'(q.slot - `SLOT_EXT_LO)] = 1'b1;
  end

  // ***************************************************************
  // next state
  // ***************************************************************

  always_comb
  begin
    d       = q;
    ext_clr = 4'h0;

    // priority registers; a level 0 pattern leaves its field alone
    for (int r = 0; r < `NUM_ISP; r++)
    begin
      if (i_wr && (i_addr == (`ADDR_ISP0 + 8'(r))))
      begin
        for (int f = 0; f < 4; f++)
        begin
          if (i_wdata[2*f +: 2] != `PRIO_L0)
            d.isp[r][2*f +: 2] = i_wdata[2*f +: 2];
        end
      end
    end
    d.isp[3] = d.isp[3] | `ISP3_RO_MASK;

    // sensitivity only accepted while interrupts are masked
    if (i_wr && (i_addr == `ADDR_SENS) && (q.cur == `PRIO_L3))
    begin
      d.sens = i_wdata;
      for (int g = 0; g < `NUM_GROUPS; g++)
        ext_clr[g] = (i_wdata[2*g +: 2] != q.sens[2*g +: 2]);
    end

    // current priority; entry outranks instruction effects
    if (acked)
    begin
      if (q.slot == `SLOT_TLI)
        d.cur = `PRIO_L3;
      else
        d.cur = q.isp[q.slot[3:2]][q.slot[1:0]*2 +: 2];
    end
    else if (i_op_trap || i_op_sim)
      d.cur = `PRIO_L3;
    else if (i_op_rim || i_op_wfi || i_op_halt)
      d.cur = `PRIO_L0;
    else if (i_op_interrupt_return_instr || i_op_pop_condition_instr)
      d.cur = {i_pop_condition_instr_data[`CC_HI_BIT], i_pop_condition_instr_data[`CC_LO_BIT]};

    // conditional jump flags track the priority they will see
    d.jump_if_masked_instr  = (d.cur == `PRIO_L3);
    d.jump_if_unmasked_instr = (d.cur != `PRIO_L3);

    // winner presented every clock; running priority is reloaded at entry
    // and by instructions, never by a field write, so a changed field acts via re-arbitration
    d.valid   = (best_lvl != 3'h0);
    d.slot    = best_slot;
    d.vaddr   = `VEC_SLOT0 - {11'h000, best_slot, 1'b0};
    d.wake_h  = |(wake_src & `WAKE_HALT);
    d.wake_ah = |(wake_src & `WAKE_AHALT);

    // read data valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (i_rd)
    begin
      for (int r = 0; r < `NUM_ISP; r++)
      begin
        if (i_addr == (`ADDR_ISP0 + 8'(r)))
          d.rdata = q.isp[r];
      end
      if (i_addr == `ADDR_SENS)
        d.rdata = q.sens;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************

  // reset runs at level 3 like the reset routine itself
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q       <= '0;
      q.isp   <= {`ISP_RESET, `ISP_RESET, `ISP_RESET, `ISP_RESET};
      q.sens  <= `SENS_RESET;
      q.cur   <= `PRIO_L3;
      q.vaddr <= `VEC_SLOT0;
      q.jump_if_masked_instr   <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs straight from the state word
  assign o_rdata            = q.rdata;
  assign o_cur_prio         = q.cur;
  assign o_irq_valid        = q.valid;
  assign o_vector_slot      = q.slot;
  assign o_vector_addr      = q.vaddr;
  assign o_wake_halt        = q.wake_h;
  assign o_wake_active_halt = q.wake_ah;
  assign o_jrm_taken        = q.jump_if_masked_instr;
  assign o_jump_if_unmasked_instr_taken       = q.jump_if_unmasked_instr;

  // ***************************************************************
  // assertions
  // ***************************************************************

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // level 0 pattern written into the third field of the first register
  sequence s_l0_write;
    i_wr && (i_addr == `ADDR_ISP0) && (i_wdata[5:4] == `PRIO_L0);
  endsequence

  // acknowledged entry of the top-level slot
  sequence s_tli_entry;
    i_int_ack && o_irq_valid && (o_vector_slot == `SLOT_TLI);
  endsequence

  // plain instruction without a competing entry
  sequence s_no_entry;
    !(i_int_ack && o_irq_valid);
  endsequence

  // inputs and priority state unchanged across the last edge
  sequence s_quiet;
    $stable(i_irq_req) && $stable(ext_pend) && $stable(q.isp) && $stable(q.cur) &&
    !i_in_halt && !i_in_active_halt && !$past(i_in_halt) && !$past(i_in_active_halt);
  endsequence

  isp_ro_bits_a: assert property (q.isp[3][7:4] == 4'hF)
    else $error("read-only priority bits not all ones");

  level0_keep_a: assert property (s_l0_write |=> q.isp[0][5:4] == $past(q.isp[0][5:4]))
    else $error("level 0 pattern was stored");

  sens_lock_a: assert property (i_wr && (i_addr == `ADDR_SENS) && (o_cur_prio != `PRIO_L3)
                                |=> $stable(q.sens))
    else $error("sensitivity changed while unmasked");

  rim_level_a: assert property (s_no_entry and (i_op_rim && !i_op_sim && !i_op_trap)
                                |=> o_cur_prio == `PRIO_L0 && o_jump_if_unmasked_instr_taken)
    else $error("enable did not load level 0");

  sim_level_a: assert property (s_no_entry and (i_op_sim || i_op_trap)
                                |=> o_cur_prio == `PRIO_L3 && o_jrm_taken)
    else $error("disable or trap did not load level 3");

  pop_restore_a: assert property (s_no_entry and (i_op_interrupt_return_instr || i_op_pop_condition_instr) and
                                  !(i_op_rim || i_op_sim || i_op_trap || i_op_wfi || i_op_halt)
                                  |=> o_cur_prio == {$past(i_pop_condition_instr_data[`CC_HI_BIT]),
                                                     $past(i_pop_condition_instr_data[`CC_LO_BIT])})
    else $error("popped priority not restored");

  tli_entry_a: assert property (s_tli_entry |=> o_cur_prio == `PRIO_L3)
    else $error("top-level entry did not mask");

  vector_map_a: assert property (o_irq_valid |-> o_vector_addr ==
                                 (`VEC_SLOT0 - {11'h000, o_vector_slot, 1'b0}))
    else $error("vector address does not match slot");

  unused_slot_a: assert property (o_irq_valid |-> (o_vector_slot != 4'h6) && (o_vector_slot != 4'h7))
    else $error("unused slot presented");

  jump_flags_a: assert property (o_jrm_taken == (o_cur_prio == `PRIO_L3) && (o_jump_if_unmasked_instr_taken != o_jrm_taken))
    else $error("jump flags disagree with priority");

  service_gate_a: assert property (s_quiet and (o_irq_valid && (o_vector_slot != `SLOT_TLI))
                                   |-> req_all[o_vector_slot] && (score[o_vector_slot] > cur_lvl))
    else $error("winner not above current level");

  // masking and wake filtering of the presented winner, and nesting of the two wake flags
  masked_gate_a: assert property ((o_cur_prio == `PRIO_L3) && $stable(o_cur_prio)
                                  |-> !o_irq_valid || (o_vector_slot == `SLOT_TLI))
    else $error("maskable winner presented at level 3");

  halt_filter_a: assert property (i_in_halt |=> !o_irq_valid || halt_wake[o_vector_slot])
    else $error("non-waking source presented in halt");

  wake_subset_a: assert property (o_wake_halt |-> o_wake_active_halt)
    else $error("halt wake without active-halt wake");

endmodule
`default_nettype wire

// ===== tb/core_partner.sv
// core model: acknowledges the winner the controller presents
// assumes registered controller outputs on the one core clock
`timescale 1ns/1ps
`default_nettype none
module core_partner
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // bench control
  input  wire logic       i_go,
  input  wire logic [3:0] i_delay,
  // controller side, plus the done flag back to the bench
  input  wire logic       i_irq_valid,
  output logic            o_int_ack,
  output logic            o_done
);
  logic [3:0] cnt_q;
  logic       busy_q;

  // stall for the chosen count, then ack once; never ack without a winner
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_q     <= 4'h0;
      busy_q    <= 1'b0;
      o_int_ack <= 1'b0;
      o_done    <= 1'b0;
    end
    else
    begin
      o_int_ack <= 1'b0;
      if (i_go)
      begin
        busy_q <= 1'b1;
        cnt_q  <= i_delay;
        o_done <= 1'b0;
      end
      else if (busy_q && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      else if (busy_q && i_irq_valid)
      begin
        o_int_ack <= 1'b1;
        busy_q    <= 1'b0;
        o_done    <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/nested_priority_interrupt_ctrl_bench.sv
// bench for the nested priority interrupt controller
// assumes the core model in core_partner.sv and the shared constants header
`timescale 1ns/1ps
`default_nettype none
`include "nic_defs.svh"
module nested_priority_interrupt_ctrl_bench;
  logic        clk, reset_n, wr, rd, go, ack, done, halt, ahalt;
  logic        valid, wake_h, wake_ah, jump_if_masked_instr, jump_if_unmasked_instr;
  logic [7:0]  addr, wdata, rdata, pop_data;
  logic [13:0] req;
  logic [3:0]  pin, slot;
  logic [6:0]  ops;
  logic [1:0]  cur;
  logic [15:0] vaddr;
  int          errors, checks;
  int          opn[8]  = '{1, 0, 4, 3, 1, 2, 6, 5};
  logic [1:0]  cexp[8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};

  nested_priority_interrupt_ctrl dut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_req(req), .i_ext_pin(pin), .i_op_rim(ops[0]),
    .i_op_sim(ops[1]), .i_op_halt(ops[2]), .i_op_wfi(ops[3]), .i_op_trap(ops[4]), .i_op_interrupt_return_instr(ops[5]),
    .i_op_pop_condition_instr(ops[6]), .i_pop_condition_instr_data(pop_data), .i_int_ack(ack), .i_in_halt(halt),
    .i_in_active_halt(ahalt), .o_cur_prio(cur), .o_irq_valid(valid), .o_vector_slot(slot),
    .o_vector_addr(vaddr), .o_wake_halt(wake_h), .o_wake_active_halt(wake_ah), .o_jrm_taken(jump_if_masked_instr),
    .o_jump_if_unmasked_instr_taken(jump_if_unmasked_instr));
  core_partner core (.i_clk(clk), .i_reset_n(reset_n), .i_go(go), .i_delay(4'h3), .i_irq_valid(valid),
    .o_int_ack(ack), .o_done(done));

  // ********************************
  // access tasks
  // ********************************
  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle strobes; read data only stands in the cycle after the strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic op(input int n, input logic [7:0] d);
    @(posedge clk);
    ops[n]   <= 1'b1;
    pop_data <= d;
    @(posedge clk);
    ops <= 7'h00;
    #1;
  endtask

  // bounded waits: an exhausted bound is a mismatch and ends the run
  task automatic wait_valid();
    for (int i = 0; i < 20 && valid !== 1'b1; i++)
      cyc(1);
    chk({15'h0, valid}, 16'h0001);
    if (valid !== 1'b1)
      end_of_test();
  endtask

  task automatic core_ack();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 20 && done !== 1'b1; i++)
      cyc(1);
    if (done !== 1'b1)
    begin
      chk({15'h0, done}, 16'h0001);
      end_of_test();
    end
    cyc(1);
  endtask

  task automatic win(input logic [3:0] s);
    chk({15'h0, valid}, 16'h0001);
    chk({12'h0, slot}, {12'h0, s});
    chk(vaddr, `VEC_SLOT0 - {11'h0, s, 1'b0});
  endtask

  // ********************************
  // clock, reset and scenarios
  // ********************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {reset_n, wr, rd, go, halt, ahalt, addr, wdata, pop_data, req, ops} = '0;
    pin = 4'hF;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk({14'h0, cur}, 16'h0003);
    for (int i = 0; i < `NUM_ISP; i++)
      rreg(`ADDR_ISP0 + 8'(i), `ISP_RESET);
    rreg(`ADDR_SENS, `SENS_RESET);
    wreg(`ADDR_SENS, 8'hAA);
    wreg(8'h25, 8'hCF);
    wreg(8'h25, 8'h64);
    rreg(8'h25, 8'h44);
    wreg(8'h28, 8'h00);
    rreg(8'h28, 8'hF0);
    wreg(8'h30, 8'h55);
    rreg(8'h30, 8'h00);
    wreg(8'h25, 8'hFF);
    wreg(8'h28, 8'hFF);
    // dedicated instructions and the jump flags
    for (int i = 0; i < 8; i++)
    begin
      op(opn[i], (opn[i] == 6) ? 8'h08 : 8'h00);
      chk({14'h0, cur}, {14'h0, cexp[i]});
      chk({jump_if_masked_instr, jump_if_unmasked_instr}, {cexp[i] == 2'h3, cexp[i] != 2'h3});
    end
    // entry, masking and re-entry after a priority change
    op(0, 8'h00);
    wreg(8'h27, 8'hFD);
    @(posedge clk);
    req <= 14'h0100;
    cyc(1);
    win(4'h8);
    core_ack();
    chk({14'h0, cur}, 16'h0001);
    cyc(1);
    chk({15'h0, valid}, 16'h0000);
    wreg(8'h27, 8'hFC);
    cyc(1);
    win(4'h8);
    // software level first, then fixed order
    op(0, 8'h00);
    @(posedge clk);
    req <= 14'h0600;
    wreg(8'h27, 8'hF3);
    cyc(1);
    win(4'hA);
    wreg(8'h27, 8'hFF);
    cyc(1);
    win(4'h9);
    // halt wake sources
    @(posedge clk);
    req  <= 14'h1E08;
    halt <= 1'b1;
    cyc(1);
    chk({wake_h, wake_ah}, 16'h0000);
    @(posedge clk);
    req <= 14'h3E08;
    cyc(1);
    chk({15'h0, wake_h}, 16'h0001);
    win(4'hD);
    @(posedge clk);
    req   <= 14'h0002;
    halt  <= 1'b0;
    ahalt <= 1'b1;
    cyc(1);
    chk({wake_h, wake_ah}, 16'h0001);
    @(posedge clk);
    ahalt <= 1'b0;
    req   <= 14'h00C0;
    cyc(1);
    chk({15'h0, valid}, 16'h0000);
    // top-level slot ignores its field and the mask
    wreg(8'h25, 8'hFD);
    op(1, 8'h00);
    @(posedge clk);
    req <= 14'h0001;
    cyc(1);
    win(4'h0);
    op(0, 8'h00);
    core_ack();
    chk({14'h0, cur}, 16'h0003);
    // external group sensitivity
    @(posedge clk);
    req <= 14'h0000;
    op(1, 8'h00);
    wreg(`ADDR_SENS, 8'h10);
    rreg(`ADDR_SENS, 8'h10);
    @(posedge clk);
    pin <= 4'hB;
    op(0, 8'h00);
    wreg(`ADDR_SENS, 8'h20);
    rreg(`ADDR_SENS, 8'h10);
    cyc(6);
    chk({15'h0, valid}, 16'h0000);
    @(posedge clk);
    pin <= 4'hF;
    wait_valid();
    win(4'h4);
    op(1, 8'h00);
    wreg(`ADDR_SENS, 8'h20);
    op(0, 8'h00);
    cyc(2);
    chk({15'h0, valid}, 16'h0000);
    @(posedge clk);
    pin <= 4'hB;
    wait_valid();
    win(4'h4);
    // both edges, then falling edge with low level
    op(1, 8'h00);
    wreg(`ADDR_SENS, 8'h30);
    op(0, 8'h00);
    cyc(2);
    chk({15'h0, valid}, 16'h0000);
    @(posedge clk);
    pin <= 4'hF;
    wait_valid();
    win(4'h4);
    op(1, 8'h00);
    wreg(`ADDR_SENS, 8'h00);
    op(0, 8'h00);
    cyc(2);
    chk({15'h0, valid}, 16'h0000);
    @(posedge clk);
    pin <= 4'hB;
    wait_valid();
    core_ack();
    chk({14'h0, cur}, 16'h0003);
    op(0, 8'h00);
    cyc(1);
    win(4'h4);
    end_of_test();
  end
endmodule
`default_nettype wire
